// ==== hdl/upg_pkg.sv ====
package upg_pkg;
	localparam logic [2:0] OFF_ACCESS_CTRL  = 3'h0;
	localparam logic [2:0] OFF_ACCESS_ADDR  = 3'h1;
	localparam logic [2:0] OFF_ACCESS_WDATA = 3'h2;
	localparam logic [2:0] OFF_ACCESS_RDATA = 3'h3;
	localparam logic [2:0] OFF_INT_STATUS   = 3'h4;
	localparam logic [2:0] OFF_INT_MASK     = 3'h5;
	localparam logic [2:0] OFF_POWER        = 3'h6;
	localparam logic [2:0] OFF_LINK_INFO    = 3'h7;

	localparam int CTRL_REQUEST = 0;
	localparam int CTRL_READ    = 1;
	localparam int CTRL_DONE    = 2;
	localparam int CTRL_BUSY    = 3;

	localparam int ST_DONE   = 0;
	localparam int ST_VBUS   = 1;
	localparam int ST_BABBLE = 2;
	localparam int ST_SOF    = 3;
	localparam int INT_W     = 4;

	localparam int PWR_SUSPEND_EN = 0;
	localparam int PWR_SUSPEND    = 1;
	localparam int PWR_RESUME     = 2;
	localparam int PWR_HALTED     = 3;

	localparam logic [INT_W-1:0] RST_INT_MASK   = 4'h0;
	localparam logic             RST_SUSPEND_EN = 1'h1;

	localparam logic [1:0] CMD_REG_WRITE = 2'h2;
	localparam logic [1:0] CMD_REG_READ  = 2'h3;
	localparam int         SYNC_W        = 11;

	typedef enum logic [2:0] {
		G_IDLE = 3'b001,
		G_HW   = 3'b010,
		G_SW   = 3'b100
	} upg_gate_e;

	typedef enum logic [5:0] {
		E_IDLE = 6'b000001,
		E_CMD  = 6'b000010,
		E_WDAT = 6'b000100,
		E_STOP = 6'b001000,
		E_TURN = 6'b010000,
		E_RDAT = 6'b100000
	} upg_eng_e;
endpackage : upg_pkg

// ==== hdl/upg_acc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface upg_acc_if;
	logic       start;
	logic       isWrite;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       done;
	logic       busy;
	modport gate   (output start, isWrite, addr, wdata, input rdata, done, busy);
	modport engine (input start, isWrite, addr, wdata, output rdata, done, busy);
endinterface : upg_acc_if
`default_nettype wire

// ==== hdl/upg_ulpi_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module upg_ulpi_engine (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       ulpiClk,
	input  wire logic       ulpiDir,
	input  wire logic       ulpiNxt,
	input  wire logic [7:0] ulpiDataIn,
	output var  logic [7:0] ulpiDataOut,
	output var  logic       ulpiDataOe,
	output var  logic       ulpiStp,
	upg_acc_if.engine       acc
);
	logic [upg_pkg::SYNC_W-1:0] pinVec;
	logic [upg_pkg::SYNC_W-1:0] syncA;
	logic [upg_pkg::SYNC_W-1:0] syncB;
	logic [upg_pkg::SYNC_W-1:0] syncC;
	logic [upg_pkg::SYNC_W-1:0] agreed;
	logic                       linkRise;
	logic                       linkDir;
	logic                       linkNxt;
	upg_pkg::upg_eng_e          state;

	assign pinVec   = {ulpiDataIn, ulpiNxt, ulpiDir, ulpiClk};
	assign linkRise = syncB[0] & syncC[0] & ~agreed[0];
	assign linkDir  = agreed[1];
	assign linkNxt  = agreed[2];

	genvar i;
	generate
		for (i = 0; i < upg_pkg::SYNC_W; i++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					syncA[i]  <= 1'b0;
					syncB[i]  <= 1'b0;
					syncC[i]  <= 1'b0;
					agreed[i] <= 1'b0;
				end else if (ce) begin
					syncA[i] <= pinVec[i];
					syncB[i] <= syncA[i];
					syncC[i] <= syncB[i];
					if (syncB[i] == syncC[i]) begin
						agreed[i] <= syncC[i];
					end
				end
			end
		end
	endgenerate

	// One register transfer at a time, retried if the PHY takes the bus during the command byte
	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= upg_pkg::E_IDLE;
			ulpiDataOut <= 8'h00;
			ulpiDataOe  <= 1'b0;
			ulpiStp     <= 1'b0;
			acc.rdata   <= 8'h00;
			acc.done    <= 1'b0;
			acc.busy    <= 1'b0;
		end else if (ce) begin
			acc.done <= 1'b0;
			if (acc.start) begin
				acc.busy <= 1'b1;
			end
			case (state)
				upg_pkg::E_IDLE: begin
					if (acc.busy && linkRise && !linkDir) begin
						ulpiDataOut <= {acc.isWrite ? upg_pkg::CMD_REG_WRITE : upg_pkg::CMD_REG_READ, acc.addr};
						ulpiDataOe  <= 1'b1;
						state       <= upg_pkg::E_CMD;
					end
				end
				upg_pkg::E_CMD: begin
					if (linkRise && linkDir) begin
						ulpiDataOe <= 1'b0;
						state      <= upg_pkg::E_IDLE;
					end else if (linkRise && linkNxt && acc.isWrite) begin
						ulpiDataOut <= acc.wdata;
						state       <= upg_pkg::E_WDAT;
					end else if (linkRise && linkNxt) begin
						ulpiDataOut <= 8'h00;
						ulpiDataOe  <= 1'b0;
						state       <= upg_pkg::E_TURN;
					end
				end
				upg_pkg::E_WDAT: begin
					if (linkRise && linkNxt) begin
						ulpiDataOut <= 8'h00;
						ulpiStp     <= 1'b1;
						state       <= upg_pkg::E_STOP;
					end
				end
				upg_pkg::E_STOP: begin
					if (linkRise) begin
						ulpiStp    <= 1'b0;
						ulpiDataOe <= 1'b0;
						acc.done   <= 1'b1;
						acc.busy   <= 1'b0;
						state      <= upg_pkg::E_IDLE;
					end
				end
				upg_pkg::E_TURN: begin
					if (linkRise && linkDir) begin
						state <= upg_pkg::E_RDAT;
					end
				end
				upg_pkg::E_RDAT: begin
					if (linkRise) begin
						acc.rdata <= agreed[10:3];
						acc.done  <= 1'b1;
						acc.busy  <= 1'b0;
						state     <= upg_pkg::E_IDLE;
					end
				end
				default: begin
					state <= upg_pkg::E_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !ce);

	a_stop_with_drive: assert property (ulpiStp |-> ulpiDataOe && state == upg_pkg::E_STOP)
		else $error("stop asserted outside the write end");
	a_done_frees_link: assert property (acc.done |-> !ulpiDataOe && !ulpiStp && !acc.busy)
		else $error("link still driven after transfer end");
endmodule : upg_ulpi_engine
`default_nettype wire

// ==== hdl/upg_gate.sv ====
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module upg_gate (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	output var  logic        irq,
	input  wire logic        hostRole,
	input  wire logic        txRequest,
	input  wire logic        txActive,
	input  wire logic        busQuiet,
	input  wire logic        vbusErrorEvt,
	input  wire logic        babbleEvt,
	input  wire logic        sofEvt,
	input  wire logic        hwAccessReq,
	input  wire logic        hwAccessWrite,
	input  wire logic [5:0]  hwAccessAddr,
	input  wire logic [7:0]  hwAccessWdata,
	output var  logic        hwAccessDone,
	output var  logic [7:0]  hwAccessRdata,
	output var  logic        txGrant,
	output var  logic        busHalted,
	output var  logic        phySuspendEnable,
	output var  logic        busSuspendReq,
	output var  logic        busResumePulse,
	input  wire logic        ulpiClk,
	input  wire logic        ulpiDir,
	input  wire logic        ulpiNxt,
	input  wire logic [7:0]  ulpiDataIn,
	output var  logic [7:0]  ulpiDataOut,
	output var  logic        ulpiDataOe,
	output var  logic        ulpiStp
);
	upg_acc_if acc ();

	upg_pkg::upg_gate_e            state;
	logic                          swPending;
	logic                          swRead;
	logic                          swDone;
	logic [5:0]                    swAddr;
	logic [7:0]                    swWdata;
	logic [7:0]                    swRdata;
	logic [upg_pkg::INT_W-1:0]     status;
	logic [upg_pkg::INT_W-1:0]     mask;
	logic [upg_pkg::INT_W-1:0]     statusSet;
	logic                          busAccess;
	logic                          regWrite;
	logic                          regRead;
	logic                          swSafe;
	logic                          launchHw;
	logic                          launchSw;
	logic                          errEvt;
	logic [31:0]                   next_readdata;

	upg_ulpi_engine u_engine (
		.clk         (clk),
		.rst         (rst),
		.ce          (ce),
		.ulpiClk     (ulpiClk),
		.ulpiDir     (ulpiDir),
		.ulpiNxt     (ulpiNxt),
		.ulpiDataIn  (ulpiDataIn),
		.ulpiDataOut (ulpiDataOut),
		.ulpiDataOe  (ulpiDataOe),
		.ulpiStp     (ulpiStp),
		.acc         (acc.engine)
	);

	assign busAccess = (read | write) & waitrequest;
	assign regWrite  = busAccess & write & byteenable[0];
	assign regRead   = busAccess & read;
	assign errEvt    = vbusErrorEvt | babbleEvt;
	// Safe when quiet bus state or no transmit
	assign swSafe    = busQuiet | busHalted | (~txActive & ~txRequest);
	assign launchHw  = (state == upg_pkg::G_IDLE) & hwAccessReq & ~hwAccessDone;
	assign launchSw  = (state == upg_pkg::G_IDLE) & ~hwAccessReq & swPending & swSafe & ~txGrant;

	assign statusSet = {sofEvt, babbleEvt, vbusErrorEvt, acc.done & (state == upg_pkg::G_SW)};

	always_comb begin
		next_readdata = 32'h0000_0000;
		case (address[4:2])
			upg_pkg::OFF_ACCESS_CTRL: begin
				next_readdata[upg_pkg::CTRL_REQUEST] = swPending;
				next_readdata[upg_pkg::CTRL_READ]    = swRead;
				next_readdata[upg_pkg::CTRL_DONE]    = swDone;
				next_readdata[upg_pkg::CTRL_BUSY]    = acc.busy;
			end
			upg_pkg::OFF_ACCESS_ADDR:  next_readdata[5:0] = swAddr;
			upg_pkg::OFF_ACCESS_WDATA: next_readdata[7:0] = swWdata;
			upg_pkg::OFF_ACCESS_RDATA: next_readdata[7:0] = swRdata;
			upg_pkg::OFF_INT_STATUS:   next_readdata[upg_pkg::INT_W-1:0] = status;
			upg_pkg::OFF_INT_MASK:     next_readdata[upg_pkg::INT_W-1:0] = mask;
			upg_pkg::OFF_POWER: begin
				next_readdata[upg_pkg::PWR_SUSPEND_EN] = phySuspendEnable;
				next_readdata[upg_pkg::PWR_SUSPEND]    = busSuspendReq;
				next_readdata[upg_pkg::PWR_HALTED]     = busHalted;
			end
			upg_pkg::OFF_LINK_INFO:    next_readdata[3:0] = {swSafe, busQuiet, txActive, hostRole};
			default:                   next_readdata = 32'h0000_0000;
		endcase
	end

	// Slave answers one cycle after the request
	always_ff @(posedge clk) begin
		if (rst) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else if (ce) begin
			if (!waitrequest) begin
				waitrequest <= 1'b1;
			end else if (read || write) begin
				waitrequest <= 1'b0;
				readdata    <= read ? next_readdata : 32'h0000_0000;
			end
		end
	end

	// Access registers, frozen while a request is pending
	always_ff @(posedge clk) begin
		if (rst) begin
			swPending <= 1'b0;
			swRead    <= 1'b0;
			swDone    <= 1'b0;
			swAddr    <= 6'h00;
			swWdata   <= 8'h00;
			swRdata   <= 8'h00;
		end else if (ce) begin
			if (state == upg_pkg::G_SW && acc.done) begin
				swPending <= 1'b0;
				swDone    <= 1'b1;
				swRdata   <= acc.rdata;
			end else if (regWrite && !swPending) begin
				case (address[4:2])
					upg_pkg::OFF_ACCESS_CTRL: begin
						swRead <= writedata[upg_pkg::CTRL_READ];
						if (writedata[upg_pkg::CTRL_REQUEST]) begin
							swPending <= 1'b1;
							swDone    <= 1'b0;
						end
					end
					upg_pkg::OFF_ACCESS_ADDR:  swAddr  <= writedata[5:0];
					upg_pkg::OFF_ACCESS_WDATA: swWdata <= writedata[7:0];
					default: begin
					end
				endcase
			end
		end
	end

	// One owner of the register engine at a time
	always_ff @(posedge clk) begin
		if (rst) begin
			state         <= upg_pkg::G_IDLE;
			acc.start     <= 1'b0;
			acc.isWrite   <= 1'b0;
			acc.addr      <= 6'h00;
			acc.wdata     <= 8'h00;
			hwAccessDone  <= 1'b0;
			hwAccessRdata <= 8'h00;
		end else if (ce) begin
			acc.start    <= 1'b0;
			hwAccessDone <= 1'b0;
			case (state)
				upg_pkg::G_IDLE: begin
					if (launchHw) begin
						acc.start   <= 1'b1;
						acc.isWrite <= hwAccessWrite;
						acc.addr    <= hwAccessAddr;
						acc.wdata   <= hwAccessWdata;
						state       <= upg_pkg::G_HW;
					end else if (launchSw) begin
						acc.start   <= 1'b1;
						acc.isWrite <= ~swRead;
						acc.addr    <= swAddr;
						acc.wdata   <= swWdata;
						state       <= upg_pkg::G_SW;
					end
				end
				upg_pkg::G_HW: begin
					if (acc.done) begin
						hwAccessDone  <= 1'b1;
						hwAccessRdata <= acc.rdata;
						state         <= upg_pkg::G_IDLE;
					end
				end
				upg_pkg::G_SW: begin
					if (acc.done) begin
						state <= upg_pkg::G_IDLE;
					end
				end
				default: begin
					state <= upg_pkg::G_IDLE;
				end
			endcase
		end
	end

	// Transmit held off while the engine is owned
	always_ff @(posedge clk) begin
		if (rst) begin
			txGrant <= 1'b0;
		end else if (ce) begin
			txGrant <= txRequest & ~busHalted & ~errEvt & (state == upg_pkg::G_IDLE) & ~launchHw & ~launchSw;
		end
	end

	// Error halts the bus until software releases it
	always_ff @(posedge clk) begin
		if (rst) begin
			busHalted <= 1'b0;
		end else if (ce) begin
			if (errEvt) begin
				busHalted <= 1'b1;
			end else if (regWrite && address[4:2] == upg_pkg::OFF_POWER && writedata[upg_pkg::PWR_HALTED]) begin
				busHalted <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phySuspendEnable <= upg_pkg::RST_SUSPEND_EN;
			busSuspendReq    <= 1'b0;
			busResumePulse   <= 1'b0;
			mask             <= upg_pkg::RST_INT_MASK;
		end else if (ce) begin
			busResumePulse <= 1'b0;
			if (regWrite && address[4:2] == upg_pkg::OFF_POWER) begin
				phySuspendEnable <= writedata[upg_pkg::PWR_SUSPEND_EN];
				busSuspendReq    <= writedata[upg_pkg::PWR_SUSPEND];
				busResumePulse   <= writedata[upg_pkg::PWR_RESUME];
			end
			if (regWrite && address[4:2] == upg_pkg::OFF_INT_MASK) begin
				mask <= writedata[upg_pkg::INT_W-1:0];
			end
		end
	end

	// Sticky flags, read clears, new event wins
	always_ff @(posedge clk) begin
		if (rst) begin
			status <= {upg_pkg::INT_W{1'b0}};
			irq    <= 1'b0;
		end else if (ce) begin
			if (regRead && address[4:2] == upg_pkg::OFF_INT_STATUS) begin
				status <= statusSet;
			end else begin
				status <= status | statusSet;
			end
			irq <= |(status & mask);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !ce);

	a_sw_blocks_tx: assert property (state == upg_pkg::G_SW |-> !txGrant)
		else $error("transmit granted during software access");
	a_launch_when_safe: assert property ($rose(state == upg_pkg::G_SW) |-> $past(swSafe) && !$past(txGrant))
		else $error("software access launched into traffic");
	a_error_halts_bus: assert property (errEvt |=> busHalted && !txGrant)
		else $error("error did not halt the bus");
	a_babble_flagged: assert property (babbleEvt |=> status[upg_pkg::ST_BABBLE])
		else $error("babble not flagged");
	a_vbus_flagged: assert property (vbusErrorEvt |=> status[upg_pkg::ST_VBUS])
		else $error("vbus error not flagged");
	a_hw_not_delayed: assert property (launchHw |=> state == upg_pkg::G_HW ##1 acc.busy)
		else $error("hardware access delayed");
	a_any_role_launch: assert property (launchSw |=> state == upg_pkg::G_SW ##1 (state == upg_pkg::G_SW && acc.busy) [*2])
		else $error("software access not launched");
	a_answer_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer timing wrong");

	c_sw_access_done: cover property (state == upg_pkg::G_SW ##[1:1000] acc.done);
	c_hw_access_done: cover property (hwAccessDone);
	c_halt_on_error: cover property (babbleEvt ##1 busHalted);
endmodule : upg_gate
`default_nettype wire

// ==== testbench/upg_phy_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module upg_phy_model (
	output var  logic       ulpiClk,
	output var  logic       ulpiDir,
	output var  logic       ulpiNxt,
	output var  logic [7:0] ulpiDataIn,
	input  wire logic [7:0] ulpiDataOut,
	input  wire logic       ulpiDataOe,
	input  wire logic       ulpiStp
);
	logic [7:0] regs [64];
	logic [7:0] lastOut;
	logic [5:0] addr;
	// Phase: 0 idle, 1 write, 2 read cmd, 3 turn, 4 data, 5 release
	logic [2:0] ph = 3'h0;
	initial begin
		ulpiClk = 1'b0;
		ulpiDir = 1'b0;
		ulpiNxt = 1'b0;
		ulpiDataIn = 8'h00;
		for (int i = 0; i < 64; i++) regs[i] = 8'(i) ^ 8'hA5;
		forever #32 ulpiClk = ~ulpiClk;
	end
	always @(posedge ulpiClk) begin
		lastOut <= ulpiDataOut;
		if (ph == 3'h0) begin
			if (ulpiDataOe === 1'b1 && ulpiDataOut[7] === 1'b1) begin
				addr <= ulpiDataOut[5:0];
				ph <= ulpiDataOut[6] ? 3'h2 : 3'h1;
			end
		end else if (ph == 3'h1) begin
			if (ulpiStp === 1'b1) begin
				regs[addr] <= lastOut;
				ph <= 3'h0;
			end
		end else if (ph == 3'h2) begin
			if (ulpiDataOe === 1'b0) ph <= 3'h3;
		end else begin
			ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
		end
	end
	// Change away from the sampling edge; idle data toggles so stale bytes never look valid
	always @(negedge ulpiClk) begin
		ulpiNxt <= (ph == 3'h1 || ph == 3'h2);
		ulpiDir <= (ph == 3'h3 || ph == 3'h4);
		ulpiDataIn <= (ph == 3'h4) ? regs[addr] : ~ulpiDataIn;
	end
endmodule : upg_phy_model
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, read = 1'b0, write = 1'b0;
	logic [4:0]  address = 5'h00;
	logic [31:0] writedata = 32'h0000_0000, readdata, rd;
	logic [3:0]  byteenable = 4'hF;
	logic        hostRole = 1'b0, txRequest = 1'b0, txActive = 1'b0, busQuiet = 1'b0;
	logic        hwAccessReq = 1'b0, hwAccessWrite = 1'b0;
	logic [2:0]  evt = 3'h0;
	logic [5:0]  hwAccessAddr = 6'h00;
	logic [7:0]  hwAccessWdata = 8'h00, hwAccessRdata, ulpiDataOut, ulpiDataIn;
	logic        waitrequest, irq, hwAccessDone, txGrant, busHalted, phySuspendEnable;
	logic        busSuspendReq, busResumePulse, ulpiClk, ulpiDir, ulpiNxt, ulpiDataOe, ulpiStp;
	logic        oeSeen = 1'b0, resSeen = 1'b0;
	int          nErrors = 0, nTests = 0, cycles = 0;

	upg_gate dut_u (.clk, .rst, .ce, .address, .read, .write, .writedata, .byteenable, .readdata,
		.waitrequest, .irq, .hostRole, .txRequest, .txActive, .busQuiet, .vbusErrorEvt(evt[0]),
		.babbleEvt(evt[1]), .sofEvt(evt[2]), .hwAccessReq, .hwAccessWrite, .hwAccessAddr,
		.hwAccessWdata, .hwAccessDone, .hwAccessRdata, .txGrant, .busHalted, .phySuspendEnable,
		.busSuspendReq, .busResumePulse, .ulpiClk, .ulpiDir, .ulpiNxt, .ulpiDataIn, .ulpiDataOut,
		.ulpiDataOe, .ulpiStp);
	upg_phy_model phy_u (.ulpiClk, .ulpiDir, .ulpiNxt, .ulpiDataIn, .ulpiDataOut, .ulpiDataOe, .ulpiStp);

	initial begin
		forever #2.5 clk = ~clk;
	end

	function automatic logic [7:0] bit8(input int i);
		return 8'h01 << i;
	endfunction : bit8

	task automatic fail(input string m);
		nErrors++;
		$display("MISMATCH %0t %s", $time, m);
	endtask : fail

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		nTests++;
		if (got !== exp) fail(m);
	endtask : chk

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (ulpiDataOe === 1'b1) oeSeen <= 1'b1;
		if (busResumePulse === 1'b1) resSeen <= 1'b1;
		if (ulpiDataOe === 1'b1 && txGrant === 1'b1) fail("grant during PHY access");
		if (cycles == 20000) begin
			fail("timeout");
			conclude();
		end
	end

	task automatic bus(input logic isRd, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		address <= {a, 2'h0};
		writedata <= {24'h00_0000, d};
		read <= isRd;
		write <= ~isRd;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic swStart(input logic isRd, input logic [5:0] a, input logic [7:0] d, input logic req);
		bus(1'h0, upg_pkg::OFF_ACCESS_ADDR, {2'h0, a});
		bus(1'h0, upg_pkg::OFF_ACCESS_WDATA, d);
		bus(1'h0, upg_pkg::OFF_ACCESS_CTRL, (isRd ? bit8(upg_pkg::CTRL_READ) : 8'h00) | 8'(req));
	endtask : swStart

	task automatic swWait();
		rd = 32'h0000_0000;
		while (rd[upg_pkg::CTRL_DONE] !== 1'b1) bus(1'h1, upg_pkg::OFF_ACCESS_CTRL, 8'h00);
	endtask : swWait

	task automatic hwAcc(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		hwAccessReq <= 1'b1;
		hwAccessWrite <= w;
		hwAccessAddr <= a;
		hwAccessWdata <= d;
		do @(posedge clk); while (hwAccessDone !== 1'b1);
		rd = {24'h00_0000, hwAccessRdata};
		hwAccessReq <= 1'b0;
	endtask : hwAcc

	task automatic pulse(input logic [2:0] e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= 3'h0;
	endtask : pulse

	task automatic tReset();
		chk(phySuspendEnable, 1'h1, "suspend enable reset");
		bus(1'h1, upg_pkg::OFF_POWER, 8'h00);
		chk(rd, bit8(upg_pkg::PWR_SUSPEND_EN), "power reset");
		byteenable <= 4'h0;
		bus(1'h0, upg_pkg::OFF_INT_MASK, 8'h0F);
		byteenable <= 4'hF;
		bus(1'h1, upg_pkg::OFF_INT_MASK, 8'h00);
		chk(rd, 32'h0000_0000, "mask reset or byte lane ignored");
		ce <= 1'b0;
		pulse(3'h1);
		repeat (2) @(posedge clk);
		chk(busHalted, 1'h0, "state frozen while ce low");
		ce <= 1'b1;
	endtask : tReset

	task automatic tTraffic();
		hostRole <= 1'b1;
		txRequest <= 1'b1;
		txActive <= 1'b1;
		swStart(1'h0, 6'h05, 8'h3C, 1'h1);
		oeSeen <= 1'b0;
		repeat (200) @(posedge clk);
		chk(oeSeen, 1'h0, "access during traffic");
		chk(txGrant, 1'h1, "traffic grant withheld");
		bus(1'h1, upg_pkg::OFF_LINK_INFO, 8'h00);
		chk(rd, 32'h0000_0003, "link info in host traffic");
		txRequest <= 1'b0;
		txActive <= 1'b0;
		swWait();
		chk(phy_u.regs[5], 8'h3C, "phy write");
		bus(1'h1, upg_pkg::OFF_INT_STATUS, 8'h00);
		chk(rd, bit8(upg_pkg::ST_DONE), "done status");
	endtask : tTraffic

	task automatic tQuiet();
		hostRole <= 1'b0;
		txActive <= 1'b1;
		busQuiet <= 1'b1;
		bus(1'h1, upg_pkg::OFF_LINK_INFO, 8'h00);
		chk(rd, 32'h0000_000E, "link info peripheral quiet");
		swStart(1'h1, 6'h21, 8'h00, 1'h1);
		swWait();
		bus(1'h1, upg_pkg::OFF_ACCESS_RDATA, 8'h00);
		chk(rd, 8'h21 ^ 8'hA5, "phy read in peripheral role");
		hwAcc(1'h1, 6'h0A, 8'hC3);
		chk(phy_u.regs[10], 8'hC3, "hardware write");
		hwAcc(1'h0, 6'h0A, 8'h00);
		chk(rd, 8'hC3, "hardware read");
		bus(1'h1, upg_pkg::OFF_INT_STATUS, 8'h00);
		txActive <= 1'b0;
		busQuiet <= 1'b0;
	endtask : tQuiet

	task automatic tErrors();
		oeSeen <= 1'b0;
		bus(1'h0, upg_pkg::OFF_INT_MASK, bit8(upg_pkg::ST_VBUS));
		txRequest <= 1'b1;
		pulse(3'h1);
		repeat (3) @(posedge clk);
		chk(busHalted, 1'h1, "vbus halt");
		chk(irq, 1'h1, "vbus irq");
		chk(txGrant, 1'h0, "grant while halted");
		bus(1'h1, upg_pkg::OFF_INT_STATUS, 8'h00);
		chk(rd, bit8(upg_pkg::ST_VBUS), "vbus status");
		repeat (2) @(posedge clk);
		chk(irq, 1'h0, "irq after read clear");
		pulse(3'h2);
		repeat (3) @(posedge clk);
		chk(irq, 1'h0, "masked babble irq");
		bus(1'h1, upg_pkg::OFF_INT_STATUS, 8'h00);
		chk(rd, bit8(upg_pkg::ST_BABBLE), "babble status");
		bus(1'h0, upg_pkg::OFF_POWER, bit8(upg_pkg::PWR_HALTED) | bit8(upg_pkg::PWR_SUSPEND_EN));
		chk(busHalted, 1'h0, "halt cleared");
		chk(oeSeen, 1'h0, "link used without any request");
		txRequest <= 1'b0;
	endtask : tErrors

	task automatic tHost();
		hostRole <= 1'b1;
		bus(1'h0, upg_pkg::OFF_POWER, 8'h00);
		chk(phySuspendEnable, 1'h0, "suspend enable cleared");
		bus(1'h0, upg_pkg::OFF_POWER, bit8(upg_pkg::PWR_SUSPEND));
		chk(busSuspendReq, 1'h1, "suspend request");
		busQuiet <= 1'b1;
		swStart(1'h0, 6'h16, 8'h9E, 1'h1);
		swWait();
		chk(phy_u.regs[22], 8'h9E, "host suspended write");
		resSeen <= 1'b0;
		bus(1'h0, upg_pkg::OFF_POWER, bit8(upg_pkg::PWR_RESUME));
		repeat (2) @(posedge clk);
		chk(resSeen, 1'h1, "resume pulse");
		bus(1'h0, upg_pkg::OFF_POWER, bit8(upg_pkg::PWR_SUSPEND_EN));
		chk(phySuspendEnable, 1'h1, "suspend enable restored");
		chk(busSuspendReq, 1'h0, "suspend released");
		busQuiet <= 1'b0;
		bus(1'h1, upg_pkg::OFF_INT_STATUS, 8'h00);
	endtask : tHost

	task automatic tSof();
		hostRole <= 1'b0;
		txActive <= 1'b1;
		bus(1'h0, upg_pkg::OFF_INT_MASK, bit8(upg_pkg::ST_SOF));
		swStart(1'h0, 6'h0B, 8'h6D, 1'h0);
		oeSeen <= 1'b0;
		repeat (100) @(posedge clk);
		chk(oeSeen, 1'h0, "preload started access");
		pulse(3'h4);
		txActive <= 1'b0;
		while (irq !== 1'b1) @(posedge clk);
		bus(1'h1, upg_pkg::OFF_INT_STATUS, 8'h00);
		chk(rd, bit8(upg_pkg::ST_SOF), "sof status");
		bus(1'h0, upg_pkg::OFF_ACCESS_CTRL, 8'h01);
		bus(1'h0, upg_pkg::OFF_INT_MASK, 8'h00);
		swWait();
		chk(phy_u.regs[11], 8'h6D, "gap write");
	endtask : tSof

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		tReset();
		tTraffic();
		tQuiet();
		tErrors();
		tHost();
		tSof();
		conclude();
	end
endmodule : testbench
`default_nettype wire
